// ===== src/sdram_cmd_pkg.sv
// package for the sdram command and configuration block
// assumes a single 25 MHz clock domain and a plain register port
package sdram_cmd_pkg;

   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_COMMAND_MODE   = 8'h00;
   localparam logic [7:0] OFS_REFRESH_PERIOD = 8'h04;
   localparam logic [7:0] OFS_GEOMETRY       = 8'h08;
   localparam logic [7:0] OFS_DECODE_CYCLE   = 8'h0C;
   localparam logic [7:0] OFS_LOW_POWER      = 8'h10;
   localparam logic [7:0] OFS_IRQ_EN_SET     = 8'h14;
   localparam logic [7:0] OFS_IRQ_EN_CLR     = 8'h18;
   localparam logic [7:0] OFS_IRQ_MASK       = 8'h1C;
   localparam logic [7:0] OFS_IRQ_PENDING    = 8'h20;
   localparam logic [7:0] OFS_DEVICE_TYPE    = 8'h24;

   // ------------------------------------------------------------
   // reset values and field layout
   // ------------------------------------------------------------
   localparam logic [31:0] RST_GEOMETRY   = 32'h852372C0;
   localparam logic [31:0] RST_ZERO       = 32'h00000000;
   localparam int          POS_COLS       = 0;
   localparam int          POS_ROWS       = 2;
   localparam int          POS_BANKS      = 4;
   localparam int          POS_CAS        = 5;
   localparam int          POS_TIMEOUT    = 12;
   localparam int          REFRESH_BITS   = 12;
   localparam logic [1:0]  CAS_RESERVED   = 2'h0;
   localparam logic [1:0]  ROWS_RESERVED  = 2'h3;
   localparam logic [1:0]  LP_OFF         = 2'h0;
   localparam logic [1:0]  LP_DEEP        = 2'h3;
   localparam logic [1:0]  TO_RESERVED    = 2'h3;

   // ------------------------------------------------------------
   // timing counts
   // ------------------------------------------------------------
   localparam logic [7:0]  TIMEOUT_64     = 8'h40;
   localparam logic [7:0]  TIMEOUT_128    = 8'h80;

   // command mode encodings
   typedef enum logic [2:0] {
      MODE_NORMAL    = 3'b000,
      MODE_NOP       = 3'b001,
      MODE_PRECHARGE = 3'b010,
      MODE_LOAD_MR   = 3'b011,
      MODE_REFRESH   = 3'b100,
      MODE_LOAD_EMR  = 3'b101,
      MODE_DEEP_PD   = 3'b110,
      MODE_UNUSED    = 3'b111
   } cmd_mode_t;

   // command emitted to the memory
   typedef enum logic [3:0] {
      CMD_IDLE      = 4'h0,
      CMD_NOP       = 4'h1,
      CMD_PRECHARGE = 4'h2,
      CMD_LOAD_MR   = 4'h3,
      CMD_REFRESH   = 4'h4,
      CMD_LOAD_EMR  = 4'h5,
      CMD_DEEP_PD   = 4'h6,
      CMD_ACCESS    = 4'h7,
      CMD_POWERDOWN = 4'h8,
      CMD_SELF_REF  = 4'h9
   } sdram_cmd_t;

   // one command to the memory with its argument
   typedef struct packed {
      sdram_cmd_t  cmd;
      logic [25:0] arg;
   } sdram_op_t;

   // decoded geometry
   typedef struct packed {
      logic [3:0] col_bits;
      logic [3:0] row_bits;
      logic [2:0] banks;
   } geometry_t;

endpackage

// ===== src/sdram_command_config.sv
// command-mode, refresh timer, geometry and low-power part of an sdram
// controller; assumes host accesses arrive as one-cycle strobes on ref_clk
//
// What this block does
// [R1] low-power field 3 sends a deep power-down command to the memory
// [R2] host issues no access after deep power-down until re-initialised
// [R3] command mode 000 decodes accesses as ordinary reads and writes
// [R4] command mode 001 turns each access into one NOP
// [R5] command mode 010 turns each access into precharge of all banks
// [R6] command mode 011 loads mode register with the access offset
// [R7] command mode 100 issues auto-refresh; host precharges beforehand
// [R8] command mode 101 loads extended mode register with access offset
// [R9] command mode 110 puts the memory into deep power-down
// [R10] 12-bit refresh count reloads a timer whose expiry starts a refresh
// [R11] no timer-driven refresh until software writes the refresh count
// [R12] software picks the count from clock, refresh rate and burst length
// [R13] column code 0..3 selects 8..11 column bits, resets to 8
// [R14] row code 0..2 selects 11..13 row bits, 3 reserved, reset 11
// [R15] bank bit selects two or four banks, resets to two
// [R16] low-power field 0 issues no low-power command at all
// [R17] low-power entry immediately, after 64 or 128 idle cycles
// [R18] refresh error flags a missed refresh; reading pending clears it
// [R19] cas latency 1..3 only, zero code reserved, reset two
// [R20] non-normal modes: one command per access, no data transferred
`timescale 1ns/1ps
`default_nettype none

module sdram_command_config
   import sdram_cmd_pkg::*;
#(
   parameter int ADDR_W = 26
) (
   input  wire logic              ref_clk,
   input  wire logic              reset_n,
   input  wire logic [7:0]        reg_addr,
   input  wire logic [31:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [31:0]       reg_rdata,
   input  wire logic              acc_req,
   input  wire logic [ADDR_W-1:0] acc_offset,
   input  wire logic              mem_done,
   output logic                   acc_done,
   output sdram_op_t              mem_op,
   output logic                   mem_op_valid,
   output geometry_t              geometry,
   output logic      [1:0]        cas_latency,
   output logic                   refresh_error
);

   // ------------------------------------------------------------
   // register file
   // ------------------------------------------------------------
   logic [2:0]              mode_q;
   logic [REFRESH_BITS-1:0] period_q;
   logic                    period_set_q;
   logic [31:0]             config_q;
   logic                    decode_q;
   logic [13:0]             lowpow_q;
   logic                    irq_mask_q;
   logic                    ref_err_q;
   logic                    ref_pend_q;
   logic                    ref_tick;

   // software writes; reserved codes are refused and keep the old value
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         mode_q       <= RST_ZERO[2:0];
         period_q     <= RST_ZERO[REFRESH_BITS-1:0];
         period_set_q <= 1'b0;
         config_q     <= RST_GEOMETRY; // R13 R14 R15 R19
         decode_q     <= 1'b0;
         lowpow_q     <= RST_ZERO[13:0];
      end else if (reg_wr) begin
         unique case (reg_addr)
            OFS_COMMAND_MODE: mode_q <= reg_wdata[2:0];
            OFS_REFRESH_PERIOD: begin
               period_q     <= reg_wdata[REFRESH_BITS-1:0];
               period_set_q <= 1'b1; // R11
            end
            OFS_GEOMETRY: begin
               config_q <= reg_wdata;
               if (reg_wdata[POS_ROWS+:2] == ROWS_RESERVED) begin
                  config_q[POS_ROWS+:2] <= config_q[POS_ROWS+:2]; // R14
               end
               if (reg_wdata[POS_CAS+:2] == CAS_RESERVED) begin
                  config_q[POS_CAS+:2] <= config_q[POS_CAS+:2]; // R19
               end
            end
            OFS_DECODE_CYCLE: decode_q <= reg_wdata[0];
            OFS_LOW_POWER: begin
               lowpow_q <= reg_wdata[13:0];
               if (reg_wdata[POS_TIMEOUT+:2] == TO_RESERVED) begin
                  lowpow_q[POS_TIMEOUT+:2] <= lowpow_q[POS_TIMEOUT+:2];
               end
            end
            default: ;
         endcase
      end
   end

   // mask set/clear pair
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         irq_mask_q <= 1'b0;
      end else if (reg_wr && reg_addr == OFS_IRQ_EN_SET && reg_wdata[0]) begin
         irq_mask_q <= 1'b1;
      end else if (reg_wr && reg_addr == OFS_IRQ_EN_CLR && reg_wdata[0]) begin
         irq_mask_q <= 1'b0;
      end
   end

   // read mux; unmapped offsets read zero, one cycle later
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         reg_rdata <= RST_ZERO;
      end else if (reg_rd) begin
         unique case (reg_addr)
            OFS_COMMAND_MODE:   reg_rdata <= {29'h0, mode_q};
            OFS_REFRESH_PERIOD: reg_rdata <= {20'h0, period_q};
            OFS_GEOMETRY:       reg_rdata <= config_q;
            OFS_DECODE_CYCLE:   reg_rdata <= {31'h0, decode_q};
            OFS_LOW_POWER:      reg_rdata <= {18'h0, lowpow_q};
            OFS_IRQ_MASK:       reg_rdata <= {31'h0, irq_mask_q};
            OFS_IRQ_PENDING:    reg_rdata <= {31'h0, ref_err_q};
            default:            reg_rdata <= RST_ZERO;
         endcase
      end else begin
         reg_rdata <= RST_ZERO;
      end
   end

   // ------------------------------------------------------------
   // geometry decode
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         geometry    <= '{col_bits: 4'h8, row_bits: 4'hB, banks: 3'h2};
         cas_latency <= 2'h2;
      end else begin
         geometry.col_bits <= 4'h8 + {2'h0, config_q[POS_COLS+:2]}; // R13
         geometry.row_bits <= 4'hB + {2'h0, config_q[POS_ROWS+:2]}; // R14
         geometry.banks    <= config_q[POS_BANKS] ? 3'h4 : 3'h2; // R15
         cas_latency       <= config_q[POS_CAS+:2]; // R19
      end
   end

   // ------------------------------------------------------------
   // refresh timer
   // ------------------------------------------------------------
   logic [REFRESH_BITS-1:0] timer_q;

   // reload on expiry; idle until the count has been written
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         timer_q  <= RST_ZERO[REFRESH_BITS-1:0];
         ref_tick <= 1'b0;
      end else if (!period_set_q || period_q == '0) begin // R11
         timer_q  <= period_q;
         ref_tick <= 1'b0;
      end else if (timer_q == '0) begin
         timer_q  <= period_q; // R10
         ref_tick <= 1'b1;
      end else begin
         timer_q  <= timer_q - 1'b1;
         ref_tick <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // command sequencer
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_BUSY = 2'b01,
      ST_DEEP = 2'b10
   } seq_state_t;

   seq_state_t  state_q;
   logic        lp_asleep_q;
   logic [7:0]  idle_cnt_q;
   logic        ref_issue;
   logic [7:0]  idle_limit;

   // host traffic outranks refresh; in deep power-down it is withheld
   assign ref_issue = ref_pend_q && state_q == ST_IDLE && !acc_req;

   always_comb begin
      unique case (lowpow_q[POS_TIMEOUT+:2]) // R17
         2'h1:    idle_limit = TIMEOUT_64;
         2'h2:    idle_limit = TIMEOUT_128;
         default: idle_limit = 8'h00;
      endcase
   end

   // a pending refresh not yet issued when the next tick comes is an error
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         ref_pend_q <= 1'b0;
         ref_err_q  <= 1'b0;
      end else begin
         if (ref_tick) begin
            ref_pend_q <= 1'b1;
         end else if (ref_issue) begin
            ref_pend_q <= 1'b0;
         end
         // set wins over the read clear
         if (ref_tick && ref_pend_q) begin
            ref_err_q <= 1'b1; // R18
         end else if (reg_rd && reg_addr == OFS_IRQ_PENDING) begin
            ref_err_q <= 1'b0; // R18
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         refresh_error <= 1'b0;
      end else begin
         refresh_error <= ref_err_q && irq_mask_q;
      end
   end

   // one command per access; data moves only in normal mode
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         state_q      <= ST_IDLE;
         mem_op       <= '{cmd: CMD_IDLE, arg: '0};
         mem_op_valid <= 1'b0;
         acc_done     <= 1'b0;
      end else begin
         mem_op_valid <= 1'b0;
         acc_done     <= 1'b0;
         unique case (state_q)
            ST_IDLE: begin
               if (lowpow_q[1:0] == LP_DEEP) begin
                  mem_op       <= '{cmd: CMD_DEEP_PD, arg: '0}; // R1
                  mem_op_valid <= 1'b1;
                  state_q      <= ST_DEEP;
               end else if (acc_req) begin
                  mem_op_valid <= 1'b1;
                  mem_op.arg   <= acc_offset;
                  unique case (cmd_mode_t'(mode_q))
                     MODE_NOP:       mem_op.cmd <= CMD_NOP; // R4
                     MODE_PRECHARGE: mem_op.cmd <= CMD_PRECHARGE; // R5
                     MODE_LOAD_MR:   mem_op.cmd <= CMD_LOAD_MR; // R6
                     MODE_REFRESH:   mem_op.cmd <= CMD_REFRESH; // R7
                     MODE_LOAD_EMR:  mem_op.cmd <= CMD_LOAD_EMR; // R8
                     MODE_DEEP_PD:   mem_op.cmd <= CMD_DEEP_PD; // R9
                     default:        mem_op.cmd <= CMD_ACCESS; // R3
                  endcase
                  if (mode_q == MODE_NORMAL) begin
                     state_q <= ST_BUSY;
                  end else if (mode_q == MODE_DEEP_PD) begin
                     acc_done <= 1'b1;
                     state_q  <= ST_DEEP;
                  end else begin
                     acc_done <= 1'b1; // R20
                  end
               end else if (ref_issue) begin
                  mem_op       <= '{cmd: CMD_REFRESH, arg: '0}; // R10
                  mem_op_valid <= 1'b1;
               end else if (lp_asleep_q == 1'b0 && lowpow_q[1:0] != LP_OFF
                            && idle_cnt_q >= idle_limit) begin
                  mem_op.cmd   <= lowpow_q[0] ? CMD_SELF_REF : CMD_POWERDOWN;
                  mem_op_valid <= 1'b1; // R16
               end
            end
            ST_BUSY: begin
               if (mem_done) begin
                  acc_done <= 1'b1;
                  state_q  <= ST_IDLE;
               end
            end
            // left only by reset or by a new command mode write
            ST_DEEP: begin
               if (reg_wr && reg_addr == OFS_COMMAND_MODE) begin
                  state_q <= ST_IDLE; // R2
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // idle counting for delayed low-power entry
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         idle_cnt_q  <= 8'h00;
         lp_asleep_q <= 1'b0;
      end else if (acc_req || state_q != ST_IDLE) begin
         idle_cnt_q  <= 8'h00;
         lp_asleep_q <= 1'b0;
      end else begin
         if (idle_cnt_q != 8'hFF) begin
            idle_cnt_q <= idle_cnt_q + 8'h01;
         end
         // asleep from the very edge that sends the entry command; waiting
         // for the command to show would let a second one out
         if (!ref_issue && lowpow_q[1:0] != LP_OFF
             && idle_cnt_q >= idle_limit) begin
            lp_asleep_q <= 1'b1; // R17
         end
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence s_nop_access;
      state_q == ST_IDLE && acc_req && mode_q == MODE_NOP
         && lowpow_q[1:0] != LP_DEEP;
   endsequence

   AST_NOP_ONE: assert property ( // R4
      @(posedge ref_clk) disable iff (!reset_n)
      s_nop_access |=> mem_op_valid && mem_op.cmd == CMD_NOP && acc_done)
      else $error("nop mode access did not give one nop");
   AST_PRECHARGE: assert property ( // R5
      @(posedge ref_clk) disable iff (!reset_n)
      state_q == ST_IDLE && acc_req && mode_q == MODE_PRECHARGE
         && lowpow_q[1:0] != LP_DEEP |=> mem_op.cmd == CMD_PRECHARGE)
      else $error("precharge mode gave wrong command");
   AST_LOAD_MR: assert property ( // R6
      @(posedge ref_clk) disable iff (!reset_n)
      state_q == ST_IDLE && acc_req && mode_q == MODE_LOAD_MR
         && lowpow_q[1:0] != LP_DEEP
         |=> mem_op.cmd == CMD_LOAD_MR && mem_op.arg == $past(acc_offset))
      else $error("mode register load lost its offset");
   AST_LOAD_EMR: assert property ( // R8
      @(posedge ref_clk) disable iff (!reset_n)
      state_q == ST_IDLE && acc_req && mode_q == MODE_LOAD_EMR
         && lowpow_q[1:0] != LP_DEEP
         |=> mem_op.cmd == CMD_LOAD_EMR && mem_op.arg == $past(acc_offset))
      else $error("extended mode register load lost its offset");
   AST_NO_DATA: assert property ( // R20
      @(posedge ref_clk) disable iff (!reset_n)
      state_q == ST_IDLE && acc_req && mode_q != MODE_NORMAL
         && lowpow_q[1:0] != LP_DEEP
         |=> mem_op_valid && acc_done && state_q != ST_BUSY)
      else $error("special mode access moved data");
   AST_NO_REFRESH: assert property ( // R11
      @(posedge ref_clk) disable iff (!reset_n)
      !period_set_q |-> !ref_tick)
      else $error("refresh tick before count written");
   AST_REFRESH_ERR: assert property ( // R18
      @(posedge ref_clk) disable iff (!reset_n)
      ref_tick && ref_pend_q |=> ref_err_q)
      else $error("missed refresh not flagged");
   AST_DEEP_PD: assert property ( // R1
      @(posedge ref_clk) disable iff (!reset_n)
      state_q == ST_IDLE && lowpow_q[1:0] == LP_DEEP
         |=> mem_op_valid && mem_op.cmd == CMD_DEEP_PD ##1 state_q == ST_DEEP)
      else $error("deep power-down not entered");
   AST_LP_OFF: assert property ( // R16
      @(posedge ref_clk) disable iff (!reset_n)
      $past(lowpow_q[1:0]) == LP_OFF && mem_op_valid
         |-> mem_op.cmd != CMD_POWERDOWN && mem_op.cmd != CMD_SELF_REF)
      else $error("low-power command while inhibited");
   AST_LP_ONCE: assert property ( // R17
      @(posedge ref_clk) disable iff (!reset_n)
      mem_op_valid && (mem_op.cmd == CMD_SELF_REF
         || mem_op.cmd == CMD_POWERDOWN)
         |=> !mem_op_valid || mem_op.cmd != $past(mem_op.cmd))
      else $error("low-power entry sent twice");
   AST_CAS_LEGAL: assert property ( // R19
      @(posedge ref_clk) disable iff (!reset_n)
      ##1 config_q[POS_CAS+:2] != CAS_RESERVED)
      else $error("reserved cas latency stored");

endmodule

`default_nettype wire

// ===== verification/sdram_mem_model.sv
// memory-side stand-in for the sdram command block
// assumes one command per valid pulse and a completion only for data moves
`timescale 1ns/1ps
`default_nettype none

module sdram_mem_model
   import sdram_cmd_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       reset_n,
   input  wire sdram_op_t  mem_op,
   input  wire logic       mem_op_valid,
   input  wire logic [7:0] done_delay,
   output logic            mem_done
);
   // ------------------------------------------------------------
   // data access timing
   // ------------------------------------------------------------
   logic [8:0] wait_q;

   // mode commands move no data, so they never get a completion
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         wait_q   <= 9'h000;
         mem_done <= 1'b0;
      end else begin
         mem_done <= (wait_q == 9'h001);
         if (mem_op_valid && mem_op.cmd == CMD_ACCESS)
            wait_q <= {1'b0, done_delay} + 9'h001;
         else if (wait_q != 9'h000)
            wait_q <= wait_q - 9'h001;
      end
   end
endmodule
`default_nettype wire

// ===== verification/test_sdram_command_config.sv
// self-checking bench for the sdram command and configuration block
// assumes the memory stand-in model and the block's package
`timescale 1ns/1ps
`default_nettype none

module test_sdram_command_config;
   import sdram_cmd_pkg::*;
   typedef struct packed {
      sdram_cmd_t  cmd;
      logic [25:0] arg;
      logic        ca;
      logic        dn;
   } exp_t;

   logic        ref_clk = 1'b0;
   logic        reset_n = 1'b0;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic        acc_req = 1'b0;
   logic [25:0] acc_offset = 26'h0;
   logic        mem_done;
   logic        acc_done;
   sdram_op_t   mem_op;
   logic        mem_op_valid;
   geometry_t   geometry;
   logic [1:0]  cas_latency;
   logic        refresh_error;
   logic [7:0]  dly = 8'h00;
   exp_t        eq[$];
   logic [31:0] rq[$];
   int          fail_count = 0;
   int          tests_run = 0;
   int          cyc = 0;
   int          op_cyc, ref_cnt, ref_gap, ref_last, t0, i, m;
   logic        allow_ref = 1'b0;
   logic        rd_pend = 1'b0;
   logic        md_q = 1'b0;
   logic        live = 1'b0;
   integer      seed = 63;
   logic [25:0] off;
   sdram_cmd_t  ctab [6] = '{CMD_NOP, CMD_PRECHARGE, CMD_LOAD_MR,
                             CMD_REFRESH, CMD_LOAD_EMR, CMD_DEEP_PD};
   logic [7:0]  ofs [9] = '{OFS_COMMAND_MODE, OFS_REFRESH_PERIOD,
                            OFS_GEOMETRY, OFS_DECODE_CYCLE, OFS_LOW_POWER,
                            OFS_IRQ_MASK, OFS_IRQ_PENDING, OFS_DEVICE_TYPE,
                            8'h28};

   sdram_command_config i_sdram_command_config (
      .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .acc_req(acc_req), .acc_offset(acc_offset),
      .mem_done(mem_done), .acc_done(acc_done), .mem_op(mem_op),
      .mem_op_valid(mem_op_valid), .geometry(geometry),
      .cas_latency(cas_latency), .refresh_error(refresh_error));

   sdram_mem_model i_sdram_mem_model (
      .ref_clk(ref_clk), .reset_n(reset_n), .mem_op(mem_op),
      .mem_op_valid(mem_op_valid), .done_delay(dly), .mem_done(mem_done));

   // ------------------------------------------------------------
   // clock, hang guard and shared tasks
   // ------------------------------------------------------------
   always #20 ref_clk = ~ref_clk;

   // whole run needs about 1000 cycles; generous ceiling
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         fail_count++;
         print_verdict();
      end
   end

   task automatic print_verdict;
      if (fail_count == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      rq.push_back(e);
      @(posedge ref_clk);
      reg_rd <= 1'b0;
   endtask

   // bounded waits: for completion, and for all notes to be used up
   task automatic wait_done;
      int k;
      for (k = 0; k < 300; k++) begin
         @(posedge ref_clk);
         if (acc_done === 1'b1)
            break;
      end
      chk("acc_wait", 32'h0, 32'(k == 300));
   endtask

   task automatic drain;
      int k;
      for (k = 0; k < 300 && (eq.size() != 0 || rq.size() != 0); k++)
         @(posedge ref_clk);
      @(posedge ref_clk);
   endtask

   task automatic acc(input logic [25:0] o, input bit wt);
      @(posedge ref_clk);
      acc_offset <= o;
      acc_req    <= 1'b1;
      @(posedge ref_clk);
      acc_req <= 1'b0;
      if (wt)
         wait_done();
   endtask

   // ------------------------------------------------------------
   // result watcher: takes the oldest note when a result appears
   // ------------------------------------------------------------
   always @(posedge ref_clk) begin
      exp_t e;
      logic dn_x;
      dn_x = md_q;
      if (rd_pend && rq.size() > 0)
         chk("reg_rdata", rq.pop_front(), reg_rdata);
      rd_pend = reg_rd;
      md_q = mem_done;
      if (mem_op_valid === 1'b1) begin
         if (allow_ref && mem_op.cmd === CMD_REFRESH) begin
            ref_cnt++;
            ref_gap = cyc - ref_last;
            ref_last = cyc;
         end else if (eq.size() == 0) begin
            chk("spare_op", 32'h0, 32'h1);
         end else begin
            e = eq.pop_front();
            chk("mem_cmd", {28'h0, e.cmd}, {28'h0, mem_op.cmd});
            if (e.ca)
               chk("mem_arg", {6'h0, e.arg}, {6'h0, mem_op.arg});
            dn_x = dn_x | e.dn;
            op_cyc = cyc;
         end
      end
      if (live)
         chk("acc_done", {31'h0, dn_x}, {31'h0, acc_done});
      live = reset_n;
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (10) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      chk("col_bits", 32'd8, 32'(geometry.col_bits));
      chk("row_bits", 32'd11, 32'(geometry.row_bits));
      chk("banks", 32'd2, 32'(geometry.banks));
      chk("cas", 32'd2, 32'(cas_latency));
      wr(OFS_IRQ_MASK, 32'hFFFFFFFF);
      wr(8'h28, 32'hFFFFFFFF);
      for (i = 0; i < 9; i++)
         rd(ofs[i], (i == 2) ? RST_GEOMETRY : RST_ZERO);
      wr(OFS_DECODE_CYCLE, 32'h1);
      rd(OFS_DECODE_CYCLE, 32'h1);
      wr(OFS_LOW_POWER, 32'h3000);
      rd(OFS_LOW_POWER, 32'h0);
      // idle with no count written: nothing may reach the memory
      repeat (300) @(posedge ref_clk);
      for (i = 0; i < 4; i++) begin
         wr(OFS_GEOMETRY, (RST_GEOMETRY & 32'hFFFFFF80) | 32'(i << 5)
            | 32'((i & 1) << 4) | 32'(i << 2) | 32'(i));
         repeat (2) @(posedge ref_clk);
         chk("col_bits", 32'(8 + i), 32'(geometry.col_bits));
         chk("row_bits", 32'((i < 3) ? 11 + i : 13),
             32'(geometry.row_bits));
         chk("banks", i[0] ? 32'd4 : 32'd2, 32'(geometry.banks));
         chk("cas", 32'((i == 0) ? 2 : i), 32'(cas_latency));
      end
      for (i = 0; i < 3; i++) begin
         dly = 8'($random(seed) & 7) + ((i == 2) ? 8'h1E : 8'h00);
         eq.push_back('{CMD_ACCESS, 26'h0, 1'b0, 1'b0});
         acc(26'($random(seed)), 1'b1);
      end
      // precharge (2) runs before auto-refresh (4) by loop order
      for (m = 1; m < 7; m++) begin
         off = 26'($random(seed));
         wr(OFS_COMMAND_MODE, 32'(m));
         rd(OFS_COMMAND_MODE, 32'(m));
         eq.push_back('{ctab[m-1], off, (m == 3 || m == 5), 1'b1});
         acc(off, 1'b1);
         drain();
      end
      wr(OFS_COMMAND_MODE, RST_ZERO);
      allow_ref = 1'b1;
      wr(OFS_REFRESH_PERIOD, 32'd40);
      rd(OFS_REFRESH_PERIOD, 32'd40);
      repeat (150) @(posedge ref_clk);
      chk("ref_count", 32'h1, 32'(ref_cnt >= 3));
      chk("ref_gap", 32'd41, 32'(ref_gap));
      // long access blocks the timer's refresh: a second tick is an error
      wr(OFS_IRQ_EN_SET, 32'h1);
      rd(OFS_IRQ_MASK, 32'h1);
      wr(OFS_REFRESH_PERIOD, 32'd10);
      dly = 8'd60;
      eq.push_back('{CMD_ACCESS, 26'h0, 1'b0, 1'b0});
      acc(26'h0, 1'b1);
      chk("ref_err", 32'h1, 32'(refresh_error));
      wr(OFS_REFRESH_PERIOD, RST_ZERO);
      repeat (15) @(posedge ref_clk);
      rd(OFS_IRQ_PENDING, 32'h1);
      drain();
      chk("ref_err", 32'h0, 32'(refresh_error));
      rd(OFS_IRQ_PENDING, 32'h0);
      wr(OFS_IRQ_EN_CLR, 32'h1);
      rd(OFS_IRQ_MASK, 32'h0);
      drain();
      allow_ref = 1'b0;
      // self-refresh 64 cycles after the end of a slow access
      dly = 8'd20;
      eq.push_back('{CMD_ACCESS, 26'h0, 1'b0, 1'b0});
      acc(26'h0, 1'b0);
      wr(OFS_LOW_POWER, 32'h1001);
      wait_done();
      t0 = cyc;
      eq.push_back('{CMD_SELF_REF, 26'h0, 1'b0, 1'b0});
      drain();
      chk("lp_delay", 32'h1,
          32'(op_cyc - t0 >= 60 && op_cyc - t0 <= 70));
      // power-down 128 cycles after the end of the next access
      wr(OFS_LOW_POWER, 32'h2002);
      dly = 8'd3;
      eq.push_back('{CMD_ACCESS, 26'h0, 1'b0, 1'b0});
      acc(26'h0, 1'b1);
      t0 = cyc;
      eq.push_back('{CMD_POWERDOWN, 26'h0, 1'b0, 1'b0});
      drain();
      chk("pd_delay", 32'h1,
          32'(op_cyc - t0 >= 124 && op_cyc - t0 <= 134));
      wr(OFS_LOW_POWER, RST_ZERO);
      eq.push_back('{CMD_DEEP_PD, 26'h0, 1'b0, 1'b0});
      wr(OFS_LOW_POWER, 32'h3);
      drain();
      acc(26'h0, 1'b0);
      repeat (10) @(posedge ref_clk);
      wr(OFS_LOW_POWER, RST_ZERO);
      wr(OFS_COMMAND_MODE, RST_ZERO);
      eq.push_back('{CMD_ACCESS, 26'h0, 1'b0, 1'b0});
      acc(26'h0, 1'b1);
      drain();
      print_verdict();
   end
endmodule
`default_nettype wire
